// ### hw/odpo_product_one.sv
// First dependency product term of one sequenced output, its
// configuration bytes and the resulting output assertion level.
// Assumes: detector, logic-input and manual-reset pins are asynchronous;
// watchdog, other-output and second-term inputs come from core_clk logic.
//
// Behaviour
// - Byte 1d bits 0-5 select primary undervoltage
// - Byte 1d bits 6,7 select the watchdogs
// - Byte 1e bits 0-5 select secondary thresholds
// - Logic inputs one-four at 1e[7:6], 1f[1:0]
// - Large variant: 1f[3:2] select outputs one, two
// - 1f[7:4] select outputs by variant numbering
// - Large variant: 23 bit 0 selects output eight
// - 40 bit 3: assert while manual reset low
// - Clear selection bit removes that signal
// - Deassert when either product term is one
`timescale 1ns/1ns
`include "odpo_defs.svh"

module odpo_product_one (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Variant strap, 1 = eight outputs and six voltage inputs
    input wire logic largeVariant,
    // Detector results, 1 = fault, index 0 = voltage input one
    input wire logic [5:0] primaryUnderVoltage,
    input wire logic [5:0] secondaryFault,
    // Watchdog timeouts, 1 = expired
    input wire logic [1:0] watchdogFault,
    // Logic inputs, 1 = condition met
    input wire logic [3:0] logicInput,
    // Manual reset pin, active low
    input wire logic manual_reset_n,
    // Other sequenced outputs, 1 = asserted, index 0 = output one
    input wire logic [7:0] otherOutputAsserted,
    // Second product term from the neighbouring table
    input wire logic productTwo,
    // Configuration port
    input wire logic cfgWriteStrobe,
    input wire logic cfgReadStrobe,
    input wire logic [7:0] cfgAddress,
    input wire logic [7:0] cfgWriteData,
    output logic [7:0] cfgReadData,
    output logic cfgReadValid,
    // Results
    output logic productOneTerm,
    output logic outputAsserted
);

    // ----------------------------------------------------------------
    // Reset release and pin synchronisation
    // ----------------------------------------------------------------
    logic rstMeta_r;
    logic rstSyncN;
    logic assertArm_r;
    logic [`ODPO_SYNC_WIDTH-1:0] pinSync;
    logic [5:0] priSync;
    logic [5:0] secSync;
    logic [3:0] logicSync;
    logic mrSyncN;
    logic largeSync;

    // Reset asserts at once, releases after two edges
    // Checks arm one edge later, once state holds computed values
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_r <= 1'b0;
            rstSyncN <= 1'b0;
            assertArm_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSyncN <= rstMeta_r;
            assertArm_r <= rstSyncN;
        end
    end

    odpo_sync u_sync (
        .core_clk(core_clk),
        .rstSyncN(rstSyncN),
        .pinAsync({largeVariant, manual_reset_n, logicInput, secondaryFault,
            primaryUnderVoltage}),
        .pinSync(pinSync)
    );

    // Split synchronised pins
    assign priSync = pinSync[5:0];
    assign secSync = pinSync[11:6];
    assign logicSync = pinSync[15:12];
    assign mrSyncN = pinSync[16];
    assign largeSync = pinSync[17];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    odpo_pkg::odpo_state_type state_r;
    odpo_pkg::odpo_state_type state_nxt;
    logic [5:0] priSel;
    logic [5:0] secSel;
    logic [1:0] wdSel;
    logic [3:0] logicSel;
    logic [7:0] outSel;
    logic mrSel;
    logic [26:0] condSel;
    logic [26:0] condOk;
    logic termNow;

    // Selection masks; small variant ignores absent inputs and outputs
    always_comb begin
        priSel = state_r.cfgPriWd[`ODPO_PRI_MSB:`ODPO_PRI_LSB]
            & {largeSync, largeSync, 4'hf};
        wdSel = {state_r.cfgPriWd[`ODPO_WD2_BIT],
            state_r.cfgPriWd[`ODPO_WD1_BIT]};
        secSel = state_r.cfgSecInLo[`ODPO_SEC_MSB:`ODPO_SEC_LSB]
            & {largeSync, largeSync, 4'hf};
        logicSel = {state_r.cfgInHiOut[`ODPO_LI4_BIT], state_r.cfgInHiOut[`ODPO_LI3_BIT],
            state_r.cfgSecInLo[`ODPO_LI2_BIT], state_r.cfgSecInLo[`ODPO_LI1_BIT]};
        mrSel = state_r.cfgManual[`ODPO_MANUAL_BIT];
        if (largeSync) begin
            // Outputs 8,7,6,5,self,3,2,1
            outSel = {state_r.cfgEighth[`ODPO_EIGHTH_BIT],
                state_r.cfgInHiOut[`ODPO_OUTF_BIT], state_r.cfgInHiOut[`ODPO_OUTE_BIT],
                state_r.cfgInHiOut[`ODPO_OUTD_BIT], 1'b0,
                state_r.cfgInHiOut[`ODPO_OUTC_BIT],
                state_r.cfgInHiOut[`ODPO_OUTB_BIT], state_r.cfgInHiOut[`ODPO_OUTA_BIT]};
        end else begin
            // Outputs 5,4,3,self,1; six to eight absent
            outSel = {3'h0, state_r.cfgInHiOut[`ODPO_OUTF_BIT],
                state_r.cfgInHiOut[`ODPO_OUTE_BIT], state_r.cfgInHiOut[`ODPO_OUTD_BIT],
                1'b0, state_r.cfgInHiOut[`ODPO_OUTC_BIT]};
        end
    end

    // Not-faulted sense of each condition, ANDed only where selected
    assign condSel = {mrSel, outSel, logicSel, wdSel, secSel, priSel};
    assign condOk = {mrSyncN, ~otherOutputAsserted, logicSync, ~watchdogFault,
        ~secSync, ~priSync};
    assign termNow = &(condOk | ~condSel);

    // Next state: register access and output evaluation
    always_comb begin
        state_nxt = state_r;
        state_nxt.readValid = cfgReadStrobe;
        if (cfgWriteStrobe) begin
            case (cfgAddress)
                `ODPO_ADDR_PRI_WD: state_nxt.cfgPriWd = cfgWriteData;
                `ODPO_ADDR_SEC_IN_LO: state_nxt.cfgSecInLo = cfgWriteData;
                `ODPO_ADDR_IN_HI_OUT: state_nxt.cfgInHiOut = cfgWriteData;
                `ODPO_ADDR_EIGHTH: state_nxt.cfgEighth = cfgWriteData;
                `ODPO_ADDR_MANUAL: state_nxt.cfgManual = cfgWriteData;
                default: state_nxt.cfgPriWd = state_r.cfgPriWd;
            endcase
        end
        if (cfgReadStrobe) begin
            case (cfgAddress)
                `ODPO_ADDR_PRI_WD: state_nxt.readData = state_r.cfgPriWd;
                `ODPO_ADDR_SEC_IN_LO: state_nxt.readData = state_r.cfgSecInLo;
                `ODPO_ADDR_IN_HI_OUT: state_nxt.readData = state_r.cfgInHiOut;
                `ODPO_ADDR_EIGHTH: state_nxt.readData = state_r.cfgEighth;
                `ODPO_ADDR_MANUAL: state_nxt.readData = state_r.cfgManual;
                default: state_nxt.readData = `ODPO_UNMAPPED_DATA;
            endcase
        end
        state_nxt.productOne = termNow;
        if (mrSel && !mrSyncN) begin
            state_nxt.outputAsserted = 1'b1;
        end else begin
            state_nxt.outputAsserted = !(termNow || productTwo);
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_r <= '{cfgPriWd: `ODPO_CFG_RESET, cfgSecInLo: `ODPO_CFG_RESET,
                cfgInHiOut: `ODPO_CFG_RESET, cfgEighth: `ODPO_CFG_RESET,
                cfgManual: `ODPO_CFG_RESET, readData: 8'h00, readValid: 1'b0,
                productOne: 1'b0, outputAsserted: 1'b1};
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flops
    assign cfgReadData = state_r.readData;
    assign cfgReadValid = state_r.readValid;
    assign productOneTerm = state_r.productOne;
    assign outputAsserted = state_r.outputAsserted;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    // Reset values are never judged against computed ones
    default disable iff (!assertArm_r);

    // Selected primary fault blocks the term
    property p_primary_blocks;
        (|(priSel & priSync)) |=> !productOneTerm;
    endproperty
    a_primary_blocks: assert property (p_primary_blocks) else $error("primary fault ignored");

    // Selected watchdog fault blocks the term
    property p_watchdog_blocks;
        (|(wdSel & watchdogFault)) |=> !productOneTerm;
    endproperty
    a_watchdog_blocks: assert property (p_watchdog_blocks) else $error("watchdog ignored");

    // Selected secondary fault on input one blocks the term
    property p_secondary_blocks;
        (state_r.cfgSecInLo[0] && secSync[0]) |=> !productOneTerm;
    endproperty
    a_secondary_blocks: assert property (p_secondary_blocks) else $error("secondary ignored");

    // Selected low fourth logic input blocks the term
    property p_logic_blocks;
        (state_r.cfgInHiOut[`ODPO_LI4_BIT] && !logicSync[3]) |=> !productOneTerm;
    endproperty
    a_logic_blocks: assert property (p_logic_blocks) else $error("logic input ignored");

    // Large variant: output two asserted blocks the term
    property p_out_two_blocks;
        (largeSync && state_r.cfgInHiOut[`ODPO_OUTB_BIT] && otherOutputAsserted[1])
            |=> !productOneTerm;
    endproperty
    a_out_two_blocks: assert property (p_out_two_blocks) else $error("output two ignored");

    // Small variant: bit 4 refers to output one
    property p_small_map;
        (!largeSync && state_r.cfgInHiOut[`ODPO_OUTC_BIT] && otherOutputAsserted[0])
            |=> !productOneTerm;
    endproperty
    a_small_map: assert property (p_small_map) else $error("variant mapping wrong");

    // Large variant: output eight asserted blocks the term
    property p_eighth_blocks;
        (largeSync && state_r.cfgEighth[0] && otherOutputAsserted[7]) |=> !productOneTerm;
    endproperty
    a_eighth_blocks: assert property (p_eighth_blocks) else $error("output eight ignored");

    // Manual reset held low keeps output asserted
    property p_manual_asserts;
        (mrSel && !mrSyncN)[*2] |=> outputAsserted;
    endproperty
    a_manual_asserts: assert property (p_manual_asserts) else $error("manual reset ignored");

    // No selection at all leaves the term true
    property p_empty_true;
        (condSel == 27'h0) |=> productOneTerm;
    endproperty
    a_empty_true: assert property (p_empty_true) else $error("empty term not true");

    // Second term deasserts output without manual override
    property p_two_deasserts;
        (productTwo && !(mrSel && !mrSyncN)) |=> !outputAsserted;
    endproperty
    a_two_deasserts: assert property (p_two_deasserts) else $error("second term ignored");

    // All selected conditions met makes the term true and output released
    property p_all_met;
        (&(condOk | ~condSel)) |=> (productOneTerm && !outputAsserted);
    endproperty
    a_all_met: assert property (p_all_met) else $error("term not true when met");

    // Read answers one cycle after its strobe
    property p_read_latency;
        cfgReadStrobe |=> cfgReadValid ##1 !cfgReadValid || $past(cfgReadStrobe);
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read valid late");

    // Large variant: secondary fault on input six blocks the term
    property p_secondary_six;
        (largeSync && state_r.cfgSecInLo[`ODPO_SEC_MSB] && secSync[5]) |=> !productOneTerm;
    endproperty
    a_secondary_six: assert property (p_secondary_six) else $error("input six ignored");

    // Low first logic input blocks the term
    property p_logic_one;
        (state_r.cfgSecInLo[`ODPO_LI1_BIT] && !logicSync[0]) |=> !productOneTerm;
    endproperty
    a_logic_one: assert property (p_logic_one) else $error("logic one ignored");

    // Large variant: output seven asserted blocks the term
    property p_out_seven;
        (largeSync && state_r.cfgInHiOut[`ODPO_OUTF_BIT] && otherOutputAsserted[6])
            |=> !productOneTerm;
    endproperty
    a_out_seven: assert property (p_out_seven) else $error("output seven ignored");

    // Manual reset selected and low also clears the term
    property p_manual_term;
        (mrSel && !mrSyncN) |=> !productOneTerm;
    endproperty
    a_manual_term: assert property (p_manual_term) else $error("manual term ignored");

    // Unmapped offsets read back as the fill value
    property p_unmapped_read;
        (cfgReadStrobe && !(cfgAddress inside {`ODPO_ADDR_PRI_WD, `ODPO_ADDR_SEC_IN_LO,
            `ODPO_ADDR_IN_HI_OUT, `ODPO_ADDR_EIGHTH, `ODPO_ADDR_MANUAL}))
            |=> (cfgReadData == `ODPO_UNMAPPED_DATA);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    // Write to the manual byte lands one edge later
    property p_write_lands;
        (cfgWriteStrobe && cfgAddress == `ODPO_ADDR_MANUAL)
            |=> (state_r.cfgManual == $past(cfgWriteData));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");

    // Main scenarios
    c_term_true: cover property (!productOneTerm ##1 productOneTerm);
    c_manual_hold: cover property ((mrSel && !mrSyncN)[*3]);
    c_large_eighth: cover property (largeSync && state_r.cfgEighth[0] && productOneTerm);
    c_release: cover property (outputAsserted ##1 !outputAsserted);
    c_small_out_one: cover property (!largeSync && outSel[0] && otherOutputAsserted[0]);

endmodule : odpo_product_one

// ### hw/odpo_defs.svh
// Offsets, field positions, reset values and timing for the
// first dependency product term of one sequenced output.
// Assumes: included by bare name from the package and the design modules.
`ifndef ODPO_DEFS_SVH
`define ODPO_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ODPO_ADDR_PRI_WD 8'h1d
`define ODPO_ADDR_SEC_IN_LO 8'h1e
`define ODPO_ADDR_IN_HI_OUT 8'h1f
`define ODPO_ADDR_EIGHTH 8'h23
`define ODPO_ADDR_MANUAL 8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ODPO_PRI_LSB 0
`define ODPO_PRI_MSB 5
`define ODPO_WD1_BIT 6
`define ODPO_WD2_BIT 7
`define ODPO_SEC_LSB 0
`define ODPO_SEC_MSB 5
`define ODPO_LI1_BIT 6
`define ODPO_LI2_BIT 7
`define ODPO_LI3_BIT 0
`define ODPO_LI4_BIT 1
`define ODPO_OUTA_BIT 2
`define ODPO_OUTB_BIT 3
`define ODPO_OUTC_BIT 4
`define ODPO_OUTD_BIT 5
`define ODPO_OUTE_BIT 6
`define ODPO_OUTF_BIT 7
`define ODPO_EIGHTH_BIT 0
`define ODPO_MANUAL_BIT 3

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define ODPO_CFG_RESET 8'h00
`define ODPO_UNMAPPED_DATA 8'h00
`define ODPO_SYNC_WIDTH 18
// Manual reset idles high, every other pin idles low
`define ODPO_SYNC_RESET 18'h10000
`define ODPO_SYNC_STAGES 2

`endif

// ### hw/odpo_pkg.sv
// Types shared by the product-term design.
// Assumes: odpo_defs.svh is on the include path.
`include "odpo_defs.svh"

package odpo_pkg;

    // State register of the product-term module, apart from the reset and pin synchroniser flops
    typedef struct packed {
        logic [7:0] cfgPriWd;
        logic [7:0] cfgSecInLo;
        logic [7:0] cfgInHiOut;
        logic [7:0] cfgEighth;
        logic [7:0] cfgManual;
        logic [7:0] readData;
        logic readValid;
        logic productOne;
        logic outputAsserted;
    } odpo_state_type;

endpackage : odpo_pkg

// ### hw/odpo_sync.sv
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes: one clock, reset already released synchronously by the caller.
`timescale 1ns/1ns
`include "odpo_defs.svh"

module odpo_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstSyncN,
    // Pins and their synchronised copies
    input wire logic [`ODPO_SYNC_WIDTH-1:0] pinAsync,
    output logic [`ODPO_SYNC_WIDTH-1:0] pinSync
);

    logic [`ODPO_SYNC_WIDTH-1:0] stageOne_r;
    localparam logic [`ODPO_SYNC_WIDTH-1:0] SYNC_RESET = `ODPO_SYNC_RESET;

    // One pair of flops per pin; first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < `ODPO_SYNC_WIDTH; gi = gi + 1) begin : g_bit
            always_ff @(posedge core_clk or negedge rstSyncN) begin
                if (!rstSyncN) begin
                    stageOne_r[gi] <= SYNC_RESET[gi];
                    pinSync[gi] <= SYNC_RESET[gi];
                end else begin
                    stageOne_r[gi] <= pinAsync[gi];
                    pinSync[gi] <= stageOne_r[gi];
                end
            end
        end
    endgenerate

endmodule : odpo_sync

// ### tb/odpo_far_side.sv
// Far-side model: supplies, watchdogs, logic inputs, other outputs.
// Assumes: the bench hands it one demand word, applied at the next edge.
`timescale 1ns/1ns

module odpo_far_side (
    // Clock
    input wire logic core_clk,
    // Requested conditions from the bench
    input wire logic [27:0] demand,
    // Condition pins toward the product term
    output logic [5:0] primaryUnderVoltage,
    output logic [5:0] secondaryFault,
    output logic [1:0] watchdogFault,
    output logic [3:0] logicInput,
    output logic manual_reset_n,
    output logic [7:0] otherOutputAsserted,
    output logic productTwo
);
    // Idle: manual reset high, everything else quiet
    logic [27:0] held_r = 28'h0040000;

    // Conditions change only just after a clock edge
    always @(posedge core_clk) begin
        held_r <= demand;
    end

    // Faults 1 = faulted; logic inputs and manual reset 1 = satisfied
    assign primaryUnderVoltage = held_r[5:0];
    assign secondaryFault = held_r[11:6];
    assign watchdogFault = held_r[13:12];
    assign logicInput = held_r[17:14];
    assign manual_reset_n = held_r[18];
    assign otherOutputAsserted = held_r[26:19];
    assign productTwo = held_r[27];
endmodule : odpo_far_side

// ### tb/odpo_product_one_test.sv
// Self-checking bench for the first product term of one sequenced output.
// Assumes: odpo_far_side drives the conditions; odpo_defs.svh on include path.
`timescale 1ns/1ns
`include "odpo_defs.svh"

module odpo_product_one_test;
    // ----------------------------------------
    // Stimulus, results and bookkeeping
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic largeVariant = 1'b1;
    logic cfgWriteStrobe = 1'b0;
    logic cfgReadStrobe = 1'b0;
    logic [7:0] cfgAddress = 8'h00;
    logic [7:0] cfgWriteData = 8'h00;
    logic [27:0] demand = 28'h0040000;
    logic chkNow = 1'b0;
    logic [31:0] seed = 32'hf6a6;
    logic [9:0] notes[$];
    logic [9:0] note;
    logic [7:0] addrs[5] = '{`ODPO_ADDR_PRI_WD, `ODPO_ADDR_SEC_IN_LO,
        `ODPO_ADDR_IN_HI_OUT, `ODPO_ADDR_EIGHTH, `ODPO_ADDR_MANUAL};
    int miscompares = 0;
    int samplesChecked = 0;
    logic [5:0] primaryUnderVoltage, secondaryFault;
    logic [1:0] watchdogFault;
    logic [3:0] logicInput;
    logic manual_reset_n, productTwo, cfgReadValid, productOneTerm, outputAsserted;
    logic [7:0] otherOutputAsserted, cfgReadData;

    // 25 MHz clock
    always #20 core_clk = ~core_clk;

    odpo_far_side far (.core_clk(core_clk), .demand(demand),
        .primaryUnderVoltage(primaryUnderVoltage), .secondaryFault(secondaryFault),
        .watchdogFault(watchdogFault), .logicInput(logicInput),
        .manual_reset_n(manual_reset_n), .otherOutputAsserted(otherOutputAsserted),
        .productTwo(productTwo));

    odpo_product_one dut (.core_clk(core_clk), .resetn(resetn),
        .largeVariant(largeVariant), .primaryUnderVoltage(primaryUnderVoltage),
        .secondaryFault(secondaryFault), .watchdogFault(watchdogFault),
        .logicInput(logicInput), .manual_reset_n(manual_reset_n),
        .otherOutputAsserted(otherOutputAsserted), .productTwo(productTwo),
        .cfgWriteStrobe(cfgWriteStrobe), .cfgReadStrobe(cfgReadStrobe),
        .cfgAddress(cfgAddress), .cfgWriteData(cfgWriteData),
        .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
        .productOneTerm(productOneTerm), .outputAsserted(outputAsserted));

    // ----------------------------------------
    // Reference model and helpers
    // ----------------------------------------
    // 32 shifts of a Galois-free feedback register per draw
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        logic [31:0] v;
        v = s;
        for (int i = 0; i < 32; i++) begin
            v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        end
        return v;
    endfunction : lfsr

    // Returns {term, output asserted}
    function automatic logic [1:0] expectTerm(input logic [7:0] c0, c1, c2, c3, c4,
            input logic [27:0] d, input logic lg);
        logic [5:0] vm;
        logic [7:0] osel;
        logic ok;
        logic man;
        vm = lg ? 6'h3f : 6'h0f;
        osel = lg ? {c3[0], c2[7:5], 1'b0, c2[4:2]} : {3'h0, c2[7:5], 1'b0, c2[4]};
        man = c4[3] & ~d[18];
        ok = ~(|(c0[5:0] & vm & d[5:0])) & ~(|(c1[5:0] & vm & d[11:6]))
            & ~(|(c0[7:6] & d[13:12])) & ~(|({c2[1:0], c1[7:6]} & ~d[17:14]))
            & ~(|(osel & d[26:19])) & ~man;
        return {ok, man | ~(ok | d[27])};
    endfunction : expectTerm

    task automatic rnd(output logic [31:0] r);
        seed = lfsr(seed);
        r = seed;
    endtask : rnd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cfgWriteStrobe <= 1'b1;
        cfgAddress <= a;
        cfgWriteData <= d;
        @(posedge core_clk);
        cfgWriteStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        notes.push_back({2'b00, e});
        @(posedge core_clk);
        cfgReadStrobe <= 1'b1;
        cfgAddress <= a;
        @(posedge core_clk);
        cfgReadStrobe <= 1'b0;
    endtask : rd

    task automatic chk(input logic [1:0] e);
        notes.push_back({1'b1, 7'h00, e});
        @(posedge core_clk);
        chkNow <= 1'b1;
        @(posedge core_clk);
        chkNow <= 1'b0;
    endtask : chk

    task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
        samplesChecked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    // Sparse random configuration and conditions, then one check
    task automatic randomCase();
        logic [31:0] a, b;
        logic [7:0] cf[5];
        logic [27:0] d;
        for (int k = 0; k < 5; k++) begin
            rnd(a);
            rnd(b);
            cf[k] = a[7:0] & b[7:0];
        end
        if (largeVariant !== 1'b1) begin
            cf[0] &= 8'hcf;
            cf[1] &= 8'hcf;
            cf[2] &= 8'hf3;
            cf[3] &= 8'hfe;
        end
        for (int k = 0; k < 5; k++) wr(addrs[k], cf[k]);
        rnd(a);
        rnd(b);
        d = (a[27:0] & b[27:0]) ^ 28'h007c000;
        demand <= d;
        repeat (6) @(posedge core_clk);
        chk(expectTerm(cf[0], cf[1], cf[2], cf[3], cf[4], d, largeVariant));
    endtask : randomCase

    task automatic summarize();
        if (notes.size() != 0) miscompares++;
        $display("checked %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // Monitor, sequence and watchdog
    // ----------------------------------------
    // Oldest note is matched to each result as it appears
    always @(posedge core_clk) begin
        if (cfgReadValid === 1'b1 || chkNow === 1'b1) begin
            note = notes.pop_front();
            if (note[9]) cmp("termOutput", {6'h00, note[1:0]},
                {6'h00, productOneTerm, outputAsserted});
            else cmp("readData", note[7:0], cfgReadData);
        end
    end

    initial begin
        logic [31:0] r;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int k = 0; k < 5; k++) rd(addrs[k], 8'h00);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        chk(2'b10);
        $display("test reset done");
        for (int k = 0; k < 5; k++) begin
            rnd(r);
            wr(addrs[k], r[7:0]);
            rd(addrs[k], r[7:0]);
        end
        $display("test registers done");
        repeat (150) randomCase();
        $display("test large variant done");
        // Mid-run reset clears every byte; the small variant follows it
        resetn <= 1'b0;
        largeVariant <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int k = 0; k < 5; k++) rd(addrs[k], 8'h00);
        chk(2'b10);
        $display("test mid-run reset done");
        repeat (150) randomCase();
        $display("test small variant done");
        repeat (3) @(posedge core_clk);
        summarize();
    end

    // Run takes about 5500 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        $display("watchdog expired");
        summarize();
    end
endmodule : odpo_product_one_test
